// ### rtl/timer_post_pkg.sv
/*
 * Constants shared by the posted-write status block: clock rates, register
 * offsets, status bit positions, reset values and channel numbering.
 * Assumes a single 20 MHz core clock; the 32 kHz side is an enable pulse.
 */
// Functional notes
// - Status bit 9 is 0 while a count-low write is pending, else 1; resets 1.
// - Status bit 8 is 0 while a posted slow-source clearance is in flight; resets 1.
// - Clearing error, done and slot-free flags acts at once, never posted.
// - Status bit 7 is 0 while a control write is pending, else 1; resets 1.
// - Status bit 6 sticks when a posting slot frees up; resets 0.
// - Slot-free flag raises the interrupt only with its control enable set.
// - Slot-free flag sets when a posted write is dispatched to the slow side.
// - Status bit 5 sticks each time a posted write becomes visible; resets 0.
// - A write to a register still pending is rejected and sets bit 4.
// - The error flag stays set through later rejections until cleared.
// - Writing one clears each sticky flag; writing zero leaves it.
// - Bits 12, 11, 10 report alarm-high, alarm-low, count-high sync likewise.
package timer_post_pkg;
    // =========================================================================
    // Rates
    localparam int unsigned REF_CLK_HZ = 20_000_000;
    localparam int unsigned SLOW_CLK_HZ = 32_768;
    localparam int unsigned SLOW_TICK_CYCLES = REF_CLK_HZ / SLOW_CLK_HZ;
    localparam int unsigned DATA_W = 16;

    // =========================================================================
    // Register byte offsets
    localparam logic [11:0] OFS_COUNT_LOW = 12'h000;
    localparam logic [11:0] OFS_COUNT_HIGH = 12'h004;
    localparam logic [11:0] OFS_ALARM_LOW = 12'h008;
    localparam logic [11:0] OFS_ALARM_HIGH = 12'h00c;
    localparam logic [11:0] OFS_CONTROL = 12'h010;
    localparam logic [11:0] OFS_STATUS = 12'h014;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h018;

    // =========================================================================
    // Posting channels, one per slow-domain register
    localparam int CH_COUNT_LOW = 0;
    localparam int CH_COUNT_HIGH = 1;
    localparam int CH_ALARM_LOW = 2;
    localparam int CH_ALARM_HIGH = 3;
    localparam int CH_CONTROL = 4;
    localparam int CH_STATUS = 5;
    localparam int NUM_CH = 6;

    // =========================================================================
    // Status bit positions and reset values
    localparam int SYNC_BIT [NUM_CH] = '{9, 10, 11, 12, 7, 8};
    localparam int RSVD13_BIT = 13;
    localparam int SLOT_FREE_BIT = 6;
    localparam int WRITE_DONE_BIT = 5;
    localparam int COLLISION_BIT = 4;
    localparam int SLOT_IRQ_EN_BIT = 15;
    localparam logic SYNC_RESET = 1'b1;
    localparam logic FLAG_RESET = 1'b0;
    localparam logic RSVD13_VALUE = 1'b1;
    localparam logic [15:0] SLOW_CLEAR_MASK = 16'h000e;
    localparam logic [15:0] MASK_RESET = 16'h0000;
endpackage

// ### rtl/post_channel.sv
/*
 * One posting slot for a slow-domain register.
 * Assumes slow_tick is a one-cycle enable at the 32 kHz rate.
 */
`timescale 1ns/1ps
module post_channel #(
    parameter int DATA_W = 16
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic slow_tick,
    // Core-side request.
    input wire logic wr_req,
    input wire logic [DATA_W-1:0] wr_data,
    // Status.
    output logic pending,
    output logic visible,
    output logic dispatched,
    output logic done,
    output logic [DATA_W-1:0] slow_q
);
    logic [DATA_W-1:0] hold;
    logic in_flight;
    logic accept;
    localparam logic SYNC_RESET_V = timer_post_pkg::SYNC_RESET;

    // =========================================================================
    // Core side
    // A write is taken only into an empty slot.
    assign accept = wr_req && !pending;

    // Slot occupancy; a tick dispatches the held word.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pending <= 1'b0;
        end else if (accept) begin
            pending <= 1'b1;
        end else if (slow_tick) begin
            pending <= 1'b0;
        end
    end

    // Data are frozen while the request stands so the slow side sees them still.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            hold <= '0;
        end else if (accept) begin
            hold <= wr_data;
        end
    end

    // =========================================================================
    // Slow side, clocked on the enable
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            slow_q <= '0;
            in_flight <= 1'b0;
        end else if (slow_tick) begin
            if (pending) begin
                slow_q <= hold;
            end
            in_flight <= pending;
        end
    end

    // The return trip costs one more tick before the result counts as visible.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            visible <= SYNC_RESET_V;
        end else if (accept) begin
            visible <= 1'b0;
        end else if (slow_tick && in_flight && !pending) begin
            visible <= 1'b1;
        end
    end

    // Event pulses for the sticky flags.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dispatched <= 1'b0;
            done <= 1'b0;
        end else begin
            dispatched <= slow_tick && pending;
            done <= slow_tick && in_flight;
        end
    end

    // =========================================================================
    // Checks
    a_accept_drops_sync: assert property (@(posedge ref_clk) disable iff (srst)
        accept |=> !visible && pending)
        else $error("accepted write left sync bit high");
    a_reject_holds_data: assert property (@(posedge ref_clk) disable iff (srst)
        wr_req && pending && !slow_tick |=> pending && $stable(hold))
        else $error("held data moved");
    a_tick_dispatches: assert property (@(posedge ref_clk) disable iff (srst)
        slow_tick && pending && !wr_req |=> dispatched && !pending && slow_q == $past(hold))
        else $error("dispatch missed");
    a_done_then_visible: assert property (@(posedge ref_clk) disable iff (srst)
        slow_tick && in_flight && !pending && !wr_req |=> done && visible)
        else $error("completion missed");
endmodule // post_channel

// ### rtl/timer_posted_write_status.sv
/*
 * Posted-write synchronisation status of a wake-up timer, with an AHB-Lite
 * register slave, six posting channels and a level interrupt.
 * Assumes one 20 MHz clock, synchronous active-high reset, a single master,
 * whole-word single transfers; the 32 kHz side runs on a divided enable.
 * Only one write per register may wait; a second one is dropped and flagged.
 * The slow tick period is a parameter so that simulations can shorten it.
 */
`timescale 1ns/1ps
module timer_posted_write_status #(
    parameter int unsigned TICK_CYCLES = timer_post_pkg::SLOW_TICK_CYCLES,
    parameter int DATA_W = timer_post_pkg::DATA_W
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic srst,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Interrupt.
    output logic irq
);
    localparam int NCH = timer_post_pkg::NUM_CH;

    logic [15:0] tick_count;
    logic slow_tick;
    logic take;
    logic wr_q;
    logic [11:0] addr_q;
    logic [NCH-1:0] sel;
    logic [NCH-1:0] ch_req;
    logic [NCH-1:0] ch_pending;
    logic [NCH-1:0] ch_visible;
    logic [NCH-1:0] ch_dispatched;
    logic [NCH-1:0] ch_done;
    logic [DATA_W-1:0] slow_q [NCH];
    logic reject;
    logic status_wr;
    logic post_slot_free_flag;
    logic post_write_done_flag;
    logic post_collision_error_flag;
    logic [15:0] irq_mask;
    logic post_slot_free_irq_enable;
    logic [15:0] status_word;
    logic next_irq;

    // =========================================================================
    // Decoding
    // Maps an offset to its posting channel, one-hot; used for writes and reads.
    function automatic logic [NCH-1:0] chan_of(input logic [11:0] ofs);
        logic [NCH-1:0] r;
        r = '0;
        unique case (ofs)
            timer_post_pkg::OFS_COUNT_LOW: r[timer_post_pkg::CH_COUNT_LOW] = 1'b1;
            timer_post_pkg::OFS_COUNT_HIGH: r[timer_post_pkg::CH_COUNT_HIGH] = 1'b1;
            timer_post_pkg::OFS_ALARM_LOW: r[timer_post_pkg::CH_ALARM_LOW] = 1'b1;
            timer_post_pkg::OFS_ALARM_HIGH: r[timer_post_pkg::CH_ALARM_HIGH] = 1'b1;
            timer_post_pkg::OFS_CONTROL: r[timer_post_pkg::CH_CONTROL] = 1'b1;
            timer_post_pkg::OFS_STATUS: r[timer_post_pkg::CH_STATUS] = 1'b1;
            default: r = '0;
        endcase
        return r;
    endfunction

    // =========================================================================
    // Slow-rate enable
    // A single clock is kept; the 32 kHz side advances on this pulse only.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tick_count <= '0;
            slow_tick <= 1'b0;
        end else if (tick_count == 16'(TICK_CYCLES - 1)) begin
            tick_count <= '0;
            slow_tick <= 1'b1;
        end else begin
            tick_count <= tick_count + 16'h0001;
            slow_tick <= 1'b0;
        end
    end

    // =========================================================================
    // Bus slave
    // Zero wait states: the slave is always ready and always answers OKAY.
    assign take = hsel && htrans[1] && hready;

    // Handshake outputs come from flops so the bus sees no combinational path.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // The address phase is latched so the write lands with hwdata next cycle.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wr_q <= 1'b0;
            addr_q <= '0;
        end else begin
            wr_q <= take && hwrite;
            addr_q <= haddr[11:0];
        end
    end

    // Read data are fetched in the address phase and stand in the data phase.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            hrdata <= '0;
        end else if (take && !hwrite) begin
            hrdata <= read_word(haddr[11:0]);
        end
    end

    // Builds a read word; unmapped offsets and unused upper lanes read zero.
    function automatic logic [31:0] read_word(input logic [11:0] ofs);
        logic [31:0] r;
        logic [NCH-1:0] c;
        r = '0;
        c = chan_of(ofs);
        for (int i = 0; i < NCH; i++) begin
            if (c[i] && i != timer_post_pkg::CH_STATUS) begin
                r[DATA_W-1:0] = slow_q[i];
            end
        end
        if (ofs == timer_post_pkg::OFS_STATUS) begin
            r[15:0] = status_word;
        end
        if (ofs == timer_post_pkg::OFS_IRQ_MASK) begin
            r[15:0] = irq_mask;
        end
        return r;
    endfunction

    // =========================================================================
    // Posting channels
    assign sel = wr_q ? chan_of(addr_q) : '0;
    assign status_wr = wr_q && (addr_q == timer_post_pkg::OFS_STATUS);

    // Status writes are posted only when they touch slow-domain sources.
    always_comb begin
        ch_req = sel;
        ch_req[timer_post_pkg::CH_STATUS] = status_wr && |(hwdata[15:0] & timer_post_pkg::SLOW_CLEAR_MASK);
    end

    // A write that finds its slot still occupied is dropped.
    assign reject = |(ch_req & ch_pending);

    generate
        for (genvar g = 0; g < NCH; g++) begin : g_ch
            post_channel #(
                .DATA_W(DATA_W)
            ) u_ch (
                .ref_clk(ref_clk),
                .srst(srst),
                .slow_tick(slow_tick),
                .wr_req(ch_req[g]),
                .wr_data(hwdata[DATA_W-1:0]),
                .pending(ch_pending[g]),
                .visible(ch_visible[g]),
                .dispatched(ch_dispatched[g]),
                .done(ch_done[g]),
                .slow_q(slow_q[g])
            );
        end
    endgenerate

    // Only the visible control word gates the interrupt, as software sees it.
    assign post_slot_free_irq_enable = slow_q[timer_post_pkg::CH_CONTROL][timer_post_pkg::SLOT_IRQ_EN_BIT];

    // =========================================================================
    // Sticky flags
    // These live in the core domain, so a one-write clears them on the spot;
    // a same-cycle event beats the clear so no event is lost.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            post_slot_free_flag <= timer_post_pkg::FLAG_RESET;
        end else if (|ch_dispatched) begin
            post_slot_free_flag <= 1'b1;
        end else if (status_wr && hwdata[timer_post_pkg::SLOT_FREE_BIT]) begin
            post_slot_free_flag <= 1'b0;
        end
    end

    // Completion flag: set, or set again, on every newly visible result.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            post_write_done_flag <= timer_post_pkg::FLAG_RESET;
        end else if (|ch_done) begin
            post_write_done_flag <= 1'b1;
        end else if (status_wr && hwdata[timer_post_pkg::WRITE_DONE_BIT]) begin
            post_write_done_flag <= 1'b0;
        end
    end

    // Later rejections find the flag already set and leave it alone.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            post_collision_error_flag <= timer_post_pkg::FLAG_RESET;
        end else if (reject) begin
            post_collision_error_flag <= 1'b1;
        end else if (status_wr && hwdata[timer_post_pkg::COLLISION_BIT]) begin
            post_collision_error_flag <= 1'b0;
        end
    end

    // =========================================================================
    // Status word
    // Sync bits read 0 while their write is pending; bit 13 reads as a constant one.
    always_comb begin
        status_word = '0;
        for (int i = 0; i < NCH; i++) begin
            status_word[timer_post_pkg::SYNC_BIT[i]] = ch_visible[i];
        end
        status_word[timer_post_pkg::RSVD13_BIT] = timer_post_pkg::RSVD13_VALUE;
        status_word[timer_post_pkg::SLOT_FREE_BIT] = post_slot_free_flag;
        status_word[timer_post_pkg::WRITE_DONE_BIT] = post_write_done_flag;
        status_word[timer_post_pkg::COLLISION_BIT] = post_collision_error_flag;
    end

    // =========================================================================
    // Interrupt
    // Mask bits share the flag layout; other bits are not stored.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq_mask <= timer_post_pkg::MASK_RESET;
        end else if (wr_q && addr_q == timer_post_pkg::OFS_IRQ_MASK) begin
            irq_mask <= '0;
            irq_mask[timer_post_pkg::SLOT_FREE_BIT] <= hwdata[timer_post_pkg::SLOT_FREE_BIT];
            irq_mask[timer_post_pkg::WRITE_DONE_BIT] <= hwdata[timer_post_pkg::WRITE_DONE_BIT];
            irq_mask[timer_post_pkg::COLLISION_BIT] <= hwdata[timer_post_pkg::COLLISION_BIT];
        end
    end

    // Slot-free needs both the mask and the control enable to reach the pin.
    assign next_irq = (post_slot_free_flag && irq_mask[timer_post_pkg::SLOT_FREE_BIT]
                       && post_slot_free_irq_enable)
        || (post_write_done_flag && irq_mask[timer_post_pkg::WRITE_DONE_BIT])
        || (post_collision_error_flag && irq_mask[timer_post_pkg::COLLISION_BIT]);

    // The pin is registered, so it trails the flags by one cycle.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

    // =========================================================================
    // Checks
    // Flag events, rejections and the clears that software makes.
    a_slot_flag_sets: assert property (@(posedge ref_clk) disable iff (srst)
        |ch_dispatched |=> post_slot_free_flag)
        else $error("slot-free flag not set");
    a_done_flag_sets: assert property (@(posedge ref_clk) disable iff (srst)
        |ch_done |=> post_write_done_flag)
        else $error("done flag not set");
    a_reject_sets_error: assert property (@(posedge ref_clk) disable iff (srst)
        reject |=> post_collision_error_flag
            && ($past(slow_tick) || |(ch_pending & $past(ch_req))))
        else $error("rejection not flagged");
    a_error_stays_set: assert property (@(posedge ref_clk) disable iff (srst)
        post_collision_error_flag && !(status_wr && hwdata[timer_post_pkg::COLLISION_BIT]) |=> post_collision_error_flag)
        else $error("error flag dropped");
    a_clear_is_immediate: assert property (@(posedge ref_clk) disable iff (srst)
        status_wr && hwdata[timer_post_pkg::WRITE_DONE_BIT] && !(|ch_done) |=> !post_write_done_flag)
        else $error("done flag clear late");
    a_slot_clear_w1c: assert property (@(posedge ref_clk) disable iff (srst)
        status_wr && hwdata[timer_post_pkg::SLOT_FREE_BIT] && !(|ch_dispatched) |=> !post_slot_free_flag)
        else $error("slot-free flag clear late");
    a_zero_keeps_done: assert property (@(posedge ref_clk) disable iff (srst)
        post_write_done_flag && status_wr && !hwdata[timer_post_pkg::WRITE_DONE_BIT] |=> post_write_done_flag)
        else $error("zero write cleared done flag");
    a_slot_flag_holds: assert property (@(posedge ref_clk) disable iff (srst)
        post_slot_free_flag && !(status_wr && hwdata[timer_post_pkg::SLOT_FREE_BIT]) |=> post_slot_free_flag)
        else $error("slot-free flag dropped");
    a_clear_posted: assert property (@(posedge ref_clk) disable iff (srst)
        status_wr && |(hwdata[15:0] & timer_post_pkg::SLOW_CLEAR_MASK) && !ch_pending[timer_post_pkg::CH_STATUS]
        |=> !ch_visible[timer_post_pkg::CH_STATUS])
        else $error("posted clearance not tracked");

    // Interrupt gating by the mask and by the visible control enable.
    a_slot_irq_gated: assert property (@(posedge ref_clk) disable iff (srst)
        post_slot_free_flag && !post_write_done_flag && !post_collision_error_flag
        && !post_slot_free_irq_enable |=> !irq)
        else $error("slot-free irq leaked");
    a_slot_irq_enabled: assert property (@(posedge ref_clk) disable iff (srst)
        post_slot_free_flag && irq_mask[timer_post_pkg::SLOT_FREE_BIT] && post_slot_free_irq_enable |=> irq)
        else $error("slot-free irq missing");
    a_error_irq: assert property (@(posedge ref_clk) disable iff (srst)
        post_collision_error_flag && irq_mask[timer_post_pkg::COLLISION_BIT] |=> irq)
        else $error("error irq missing");
endmodule // timer_posted_write_status

// ### verif/tb.sv
/*
 * Self-checking bench for the posted-write status block: an AHB-Lite master
 * task pair, an integer model of the status word, and sticky-flag checks.
 * Assumes the slave answers with hreadyout and a shortened slow tick period.
 */
`timescale 1ns/1ps
module tb;
    // =========================================================================
    // Signals and model state
    localparam int unsigned TICKS = 64;
    localparam logic [11:0] ST = timer_post_pkg::OFS_STATUS;
    localparam logic [11:0] MASK = timer_post_pkg::OFS_IRQ_MASK;
    logic ref_clk, srst, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rd, data;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int bad_count, checks_done, exp_st;

    timer_posted_write_status #(.TICK_CYCLES(TICKS), .DATA_W(timer_post_pkg::DATA_W)) uut (
        .ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));

    // The only slave drives the bus ready.
    assign hready = hreadyout;

    // =========================================================================
    // Clock, 50 ns period.
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // =========================================================================
    // Comparison and verdict tasks.
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_irq(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t irq got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        if (bad_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // =========================================================================
    // Bus master: address phase held until ready, then data phase until ready.
    task automatic ahb_xfer(input logic [11:0] a, input logic wr, input logic [31:0] d, output logic [31:0] v);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wr ? d : 32'h0;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        v = hrdata;
        chk_word({31'h0, hresp}, 32'h0);
    endtask

    task automatic ahb_write(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        ahb_xfer(a, 1'b1, d, dummy);
    endtask

    task automatic ahb_read(input logic [11:0] a, output logic [31:0] v);
        ahb_xfer(a, 1'b0, 32'h0, v);
    endtask

    // Polling is bounded; a bit that never returns shows in the next compare.
    task automatic wait_sync(input int b);
        for (int i = 0; i < 100; i++) begin
            ahb_read(ST, rd);
            if (rd[b] === 1'b1) break;
        end
    endtask

    // Post one write, optionally collide twice, and follow it to visibility.
    task automatic post_check(input int ch, input logic [11:0] a, input logic [31:0] d, input logic dup);
        int b;
        b = timer_post_pkg::SYNC_BIT[ch];
        ahb_write(a, d);
        if (dup) begin
            ahb_write(a, ~d);
            ahb_write(a, d ^ 32'h5);
            exp_st = exp_st | 32'h10;
        end
        ahb_read(ST, rd);
        chk_word(rd, 32'(exp_st & ~(1 << b)));
        wait_sync(b);
        ahb_read(ST, rd);
        chk_word(rd, 32'(exp_st | 32'h60));
        if (ch != timer_post_pkg::CH_STATUS) begin
            ahb_read(a, rd);
            chk_word(rd, d & 32'hffff);
        end
    endtask

    // =========================================================================
    // Main sequence.
    initial begin
        srst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        bad_count = 0;
        checks_done = 0;
        exp_st = 32'h3f80;
        void'($urandom(44));
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        // Reset values, mask layout and an unmapped word.
        ahb_read(ST, rd);
        chk_word(rd, 32'h3f80);
        chk_irq(irq, 1'b0);
        ahb_read(MASK, rd);
        chk_word(rd, 32'h0);
        ahb_write(12'h01c, 32'hffff);
        ahb_read(12'h01c, rd);
        chk_word(rd, 32'h0);
        ahb_write(MASK, 32'hffff);
        ahb_read(MASK, rd);
        chk_word(rd, 32'h70);
        ahb_write(MASK, 32'h10);
        // Colliding writes early, long before the first slow tick.
        data = {16'h0, 16'($urandom)};
        post_check(timer_post_pkg::CH_COUNT_LOW, timer_post_pkg::OFS_COUNT_LOW, data, 1'b1);
        chk_irq(irq, 1'b1);
        // Writing zero keeps flags; writing one clears them at once.
        ahb_write(ST, 32'h0);
        ahb_read(ST, rd);
        chk_word(rd, 32'h3ff0);
        ahb_write(ST, 32'h10);
        ahb_read(ST, rd);
        chk_word(rd, 32'h3fe0);
        chk_irq(irq, 1'b0);
        ahb_write(ST, 32'h60);
        ahb_read(ST, rd);
        chk_word(rd, 32'h3f80);
        exp_st = 32'h3f80;
        // Slot-free flag is masked in but its enable is still off.
        ahb_write(MASK, 32'h40);
        for (int ch = 0; ch < 4; ch++) begin
            data = {16'h0, 16'($urandom)};
            post_check(ch, 12'(4 * ch), data, 1'b0);
            chk_irq(irq, 1'b0);
            ahb_write(ST, 32'h60);
        end
        // Enable bit arrives through the posted control write itself.
        data = {16'h0, 1'b1, 15'($urandom)};
        post_check(timer_post_pkg::CH_CONTROL, timer_post_pkg::OFS_CONTROL, data, 1'b0);
        chk_irq(irq, 1'b1);
        ahb_write(ST, 32'h60);
        ahb_read(ST, rd);
        chk_word(rd, 32'h3f80);
        chk_irq(irq, 1'b0);
        // A clearance of slow-side sources is posted and tracked.
        post_check(timer_post_pkg::CH_STATUS, ST, 32'he, 1'b0);
        stop_test;
    end

    // =========================================================================
    // Watchdog: the whole sequence needs well under 10000 cycles.
    initial begin
        repeat (30000) @(posedge ref_clk);
        bad_count++;
        stop_test;
    end
endmodule // tb
